// File: common/sli_pkg.sv
// Package with constants, register map and state types of the serial link init and error block
package sli_pkg;
    // Channel geometry
    localparam int unsigned SLI_LANES = 4;
    localparam int unsigned SLI_DW = 16;
    localparam int unsigned SLI_AW = 4;

    // Register offsets (byte addresses)
    localparam logic [3:0] SLI_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SLI_ADDR_STATUS = 4'h4;
    localparam logic [3:0] SLI_ADDR_ERR = 4'h8;
    localparam logic [3:0] SLI_ADDR_LEAK = 4'hC;

    // Field positions
    localparam int unsigned SLI_CTRL_SIMPLEX_BIT = 0;
    localparam int unsigned SLI_CTRL_RESTART_BIT = 1;
    localparam int unsigned SLI_STAT_LINK_BIT = 4;
    localparam int unsigned SLI_STAT_TXUP_BIT = 5;
    localparam int unsigned SLI_ERR_SOFT_BIT = 0;
    localparam int unsigned SLI_ERR_FRAME_BIT = 1;
    localparam int unsigned SLI_ERR_TXF_BIT = 2;
    localparam int unsigned SLI_ERR_RXF_BIT = 3;

    // Values after reset
    localparam logic SLI_SIMPLEX_RST = 1'b0;
    localparam logic [7:0] SLI_LEAK_THR_RST = 8'h08;

    // Cycle counts and the verify sequence count
    localparam logic [11:0] SLI_LEAK_PERIOD_CYC = 12'h0FF;
    localparam logic [3:0] SLI_RST_HOLD_CYC = 4'h8;
    localparam logic [2:0] SLI_VERIFY_CNT = 3'h4;
    localparam int unsigned SLI_WATCHDOG_CYC = 16384;

    // Receive channel initialization states
    typedef enum logic [2:0] {
        CH_RESET,
        CH_LANE,
        CH_BOND,
        CH_VERIFY,
        CH_READY
    } sli_chan_state_t;

    // Simplex transmit states, stepped by sideband indications
    typedef enum logic [2:0] {
        TX_RESET,
        TX_ALIGNED,
        TX_BONDED,
        TX_UP
    } sli_tx_state_t;
endpackage

// File: verilog/sli_core.sv
// Channel initialization, error classification and register port of the serial link core
// Function
// [R1] Restart initialization after power-up, reset, fatal error
// [R2] Per-lane ready bit after lane initialization
// [R3] Link ready only after complete initialization
// [R4] Receiver qualifies data by stream valid only
// [R5] No transmit before link ready
// [R6] No receive delivery until all lanes ready
// [R7] Symbol error flagged every erroring cycle
// [R8] Invalid code or disparity is symbol error
// [R9] Transmit-only side lacks symbol and framing errors
// [R10] Transceiver faults to transmit/receive fatal outputs
// [R11] Leaky bucket escalates symbol errors to fatal
// [R12] Fatal error resets core, reinitializes
// [R13] Symbol errors alone never reset core
// [R14] Framing error: empty, double start, double end
// [R15] Transmit buffer over/underflow is fatal
// [R16] Receive buffer over/underflow is fatal
// [R17] Illegal transmit control character is fatal
// [R18] Unknown received control character is framing error
// [R19] Bad flow-message length is framing error
// [R20] Simplex sides exchange sideband init state
// [R21] Bonding indication used only multi-lane
// [R22] Transmit sideband from relay or timers
// [R23] Reset six cycles, link drops after three; code holds reset until its hold count reaches SLI_RST_HOLD_CYC = 8
// [R24] Flags synchronous and cleared by reset
//
// The placing of the registers and the strobed register port are this design's own decisions.
module sli_core #(
    parameter int unsigned WATCHDOG_CYC = sli_pkg::SLI_WATCHDOG_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [sli_pkg::SLI_AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Channel reset pin and receive lane status from the decoders
    input wire logic chan_reset_i,
    input wire logic [sli_pkg::SLI_LANES-1:0] lane_aligned_i,
    input wire logic bond_done_i,
    input wire logic verify_seen_i,
    input wire logic [sli_pkg::SLI_LANES-1:0] code_invalid_i,
    input wire logic [sli_pkg::SLI_LANES-1:0] disp_err_i,
    input wire logic rx_buf_err_i,
    input wire logic tx_buf_err_i,
    input wire logic tx_bad_ctrl_i,
    input wire logic rx_unknown_ctrl_i,
    input wire logic user_flow_message_len_bad_i,
    input wire logic rx_sof_i,
    input wire logic rx_eof_i,
    input wire logic rx_data_i,
    input wire logic [sli_pkg::SLI_DW-1:0] rx_word_i,
    input wire logic rx_word_valid_i,
    // Simplex transmit sideband inputs
    input wire logic tx_aligned_i,
    input wire logic tx_bonded_i,
    input wire logic tx_verify_i,
    input wire logic tx_reset_i,
    // Status and data outputs
    output logic [sli_pkg::SLI_LANES-1:0] lane_ready_o,
    output logic link_ready_o,
    output logic tx_link_ready_o,
    output logic tx_en_o,
    output logic soft_err_o,
    output logic frame_err_o,
    output logic tx_fatal_o,
    output logic rx_fatal_o,
    output logic rx_aligned_o,
    output logic rx_bonded_o,
    output logic rx_verify_o,
    output logic rx_reset_o,
    output logic [sli_pkg::SLI_DW-1:0] rx_tdata_o,
    output logic rx_tvalid_o
);
    import sli_pkg::*;

    localparam logic MULTI_LANE = (SLI_LANES > 1);
    localparam logic [14:0] WD_LIMIT = 15'(WATCHDOG_CYC - 1);

    sli_chan_state_t state_q, state_d;
    sli_tx_state_t tx_state_q, tx_state_d;
    logic [4:0] pin_s1_q, pin_s2_q;
    logic chan_rst_s, tx_aligned_s, tx_bonded_s, tx_verify_s, tx_reset_s;
    logic simplex_q, restart_pulse_q;
    logic [7:0] leak_thr_q;
    logic [3:0] err_sticky_q;
    logic [SLI_LANES-1:0] lane_ready_q;
    logic [3:0] hold_q;
    logic [14:0] wd_q;
    logic [2:0] vcnt_q;
    logic [7:0] bucket_q, bucket_d;
    logic [11:0] leak_tmr_q;
    logic in_frame_q, data_seen_q;
    logic sym_err, bucket_full, tx_fatal_ev, rx_fatal_ev, restart_req, wd_expired;
    logic frame_err_ev, sof_dup, eof_orphan, frame_empty;

    // Pins from the far side pass two flops; nothing reads stage one but stage two
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end else begin
            pin_s1_q <= {chan_reset_i, tx_aligned_i, tx_bonded_i, tx_verify_i, tx_reset_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign {chan_rst_s, tx_aligned_s, tx_bonded_s, tx_verify_s, tx_reset_s} = pin_s2_q;

    // Error events; the transmit-only path has no symbol or framing checks
    assign sym_err = |(code_invalid_i | disp_err_i);  // [R8]
    assign tx_fatal_ev = tx_buf_err_i | tx_bad_ctrl_i;  // [R15] [R17] [R9]
    assign rx_fatal_ev = rx_buf_err_i | bucket_full;  // [R16] [R11]
    // Fatal flags and the reset pin restart; symbol errors act only via the bucket
    assign restart_req = chan_rst_s | restart_pulse_q | tx_fatal_o | rx_fatal_o;  // [R12] [R13] [R23]
    assign wd_expired = (wd_q == WD_LIMIT);

    // Register writes: mode, one-shot restart and leak threshold
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            simplex_q <= SLI_SIMPLEX_RST;
            restart_pulse_q <= 1'b0;
            leak_thr_q <= SLI_LEAK_THR_RST;
        end else begin
            restart_pulse_q <= reg_wr_i && reg_addr_i == SLI_ADDR_CTRL && reg_wdata_i[SLI_CTRL_RESTART_BIT];
            if (reg_wr_i && reg_addr_i == SLI_ADDR_CTRL) begin
                simplex_q <= reg_wdata_i[SLI_CTRL_SIMPLEX_BIT];
            end
            if (reg_wr_i && reg_addr_i == SLI_ADDR_LEAK) begin
                leak_thr_q <= reg_wdata_i[7:0];
            end
        end
    end

    // Sticky error bits: write one to clear, a new event in the same cycle wins
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err_sticky_q <= 4'h0;
        end else begin
            err_sticky_q <= (err_sticky_q & ~((reg_wr_i && reg_addr_i == SLI_ADDR_ERR) ? reg_wdata_i[3:0] : 4'h0))
                | {rx_fatal_ev, tx_fatal_ev, frame_err_ev, sym_err};
        end
    end

    // Read data stands for the one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    SLI_ADDR_CTRL: reg_rdata_o <= {31'h0000_0000, simplex_q};
                    SLI_ADDR_STATUS: reg_rdata_o <= {26'h000_0000, tx_link_ready_o, link_ready_o, lane_ready_q};
                    SLI_ADDR_ERR: reg_rdata_o <= {28'h000_0000, err_sticky_q};
                    SLI_ADDR_LEAK: reg_rdata_o <= {24'h00_0000, leak_thr_q};
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Channel initialization sequence, retried by the watchdog until ready
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CH_RESET: if (hold_q == SLI_RST_HOLD_CYC) state_d = CH_LANE;  // [R1]
            CH_LANE: if (&lane_ready_q) state_d = MULTI_LANE ? CH_BOND : CH_VERIFY;  // [R21]
            CH_BOND: if (bond_done_i) state_d = CH_VERIFY;
            CH_VERIFY: if (vcnt_q == SLI_VERIFY_CNT) state_d = CH_READY;  // [R3]
            CH_READY: state_d = CH_READY;
            default: state_d = CH_RESET;
        endcase
        if (state_q != CH_READY && state_q != CH_RESET && wd_expired) begin
            state_d = CH_RESET;  // [R1]
        end
        if (restart_req) begin
            state_d = CH_RESET;  // [R12]
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= CH_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Reset hold, watchdog and verify counters, all restarted on a state change
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_q <= 4'h0;
            wd_q <= 15'h0000;
            vcnt_q <= 3'h0;
        end else begin
            hold_q <= (state_d == CH_RESET && state_q == CH_RESET && !restart_req) ? hold_q + 4'h1 : 4'h0;
            wd_q <= (state_d == state_q && !wd_expired) ? wd_q + 15'h0001 : 15'h0000;
            if (state_q != CH_VERIFY) begin
                vcnt_q <= 3'h0;
            end else if (verify_seen_i) begin
                vcnt_q <= vcnt_q + 3'h1;
            end
        end
    end

    // Lane ready bits latch during lane initialization and clear on restart
    generate
        for (genvar i = 0; i < SLI_LANES; i++) begin : g_lane
            always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    lane_ready_q[i] <= 1'b0;
                end else if (state_d == CH_RESET) begin
                    lane_ready_q[i] <= 1'b0;
                end else if (lane_aligned_i[i]) begin
                    lane_ready_q[i] <= 1'b1;  // [R2]
                end
            end
        end
    endgenerate

    // Simplex transmit side follows the synchronised sideband indications
    always_comb begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            TX_RESET: if (tx_aligned_s) tx_state_d = TX_ALIGNED;  // [R20]
            TX_ALIGNED: if (tx_bonded_s || !MULTI_LANE) tx_state_d = TX_BONDED;  // [R21]
            TX_BONDED: if (tx_verify_s) tx_state_d = TX_UP;
            TX_UP: tx_state_d = TX_UP;
            default: tx_state_d = TX_RESET;
        endcase
        if (tx_reset_s || !simplex_q || chan_rst_s || tx_fatal_o) begin
            tx_state_d = TX_RESET;  // [R12]
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state_q <= TX_RESET;
        end else begin
            tx_state_q <= tx_state_d;
        end
    end

    // Leaky bucket: fill on each erroring cycle, drain one per leak period
    always_comb begin
        bucket_d = bucket_q;
        if (sym_err && bucket_d != 8'hFF) begin
            bucket_d = bucket_d + 8'h01;
        end
        if (leak_tmr_q == SLI_LEAK_PERIOD_CYC && bucket_d != 8'h00) begin
            bucket_d = bucket_d - 8'h01;
        end
    end
    assign bucket_full = (bucket_q >= leak_thr_q) && (leak_thr_q != 8'h00);  // [R11]

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bucket_q <= 8'h00;
            leak_tmr_q <= 12'h000;
        end else begin
            leak_tmr_q <= (leak_tmr_q == SLI_LEAK_PERIOD_CYC) ? 12'h000 : leak_tmr_q + 12'h001;
            bucket_q <= (state_q == CH_RESET) ? 8'h00 : bucket_d;  // [R11]
        end
    end

    // Frame tracking for truncated and empty frames
    assign sof_dup = rx_sof_i && in_frame_q;
    assign eof_orphan = rx_eof_i && !in_frame_q && !rx_sof_i;
    assign frame_empty = rx_eof_i && (rx_sof_i || in_frame_q) && !rx_data_i && !(data_seen_q && !rx_sof_i);
    assign frame_err_ev = sof_dup || eof_orphan || frame_empty  // [R14]
        || rx_unknown_ctrl_i || user_flow_message_len_bad_i;  // [R18] [R19]

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            in_frame_q <= 1'b0;
            data_seen_q <= 1'b0;
        end else if (rx_eof_i) begin
            in_frame_q <= 1'b0;
            data_seen_q <= 1'b0;
        end else if (rx_sof_i) begin
            in_frame_q <= 1'b1;
            data_seen_q <= rx_data_i;
        end else if (rx_data_i) begin
            data_seen_q <= 1'b1;
        end
    end

    // Error outputs: one registered pulse per erroring cycle, cleared by reset
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            soft_err_o <= 1'b0;
            frame_err_o <= 1'b0;
            tx_fatal_o <= 1'b0;
            rx_fatal_o <= 1'b0;
        end else begin
            soft_err_o <= sym_err;  // [R7] [R24]
            frame_err_o <= frame_err_ev;  // [R14]
            tx_fatal_o <= tx_fatal_ev;  // [R10]
            rx_fatal_o <= rx_fatal_ev;  // [R10]
        end
    end

    // Readiness, sideband and transmit-enable outputs follow the next state
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lane_ready_o <= '0;
            link_ready_o <= 1'b0;
            tx_link_ready_o <= 1'b0;
            tx_en_o <= 1'b0;
            rx_aligned_o <= 1'b0;
            rx_bonded_o <= 1'b0;
            rx_verify_o <= 1'b0;
            rx_reset_o <= 1'b1;
        end else begin
            lane_ready_o <= (state_d == CH_RESET) ? '0 : (lane_ready_q | lane_aligned_i);  // [R2]
            link_ready_o <= (state_d == CH_READY);  // [R3] [R23]
            tx_link_ready_o <= (tx_state_d == TX_UP);
            tx_en_o <= simplex_q ? (tx_state_d == TX_UP) : (state_d == CH_READY);  // [R5]
            rx_aligned_o <= (state_d != CH_RESET) && (state_d != CH_LANE);  // [R20]
            rx_bonded_o <= MULTI_LANE && (state_d == CH_VERIFY || state_d == CH_READY);  // [R21]
            rx_verify_o <= (state_d == CH_READY);
            rx_reset_o <= (state_d == CH_RESET);
        end
    end

    // Receive data pass only once every lane and the channel are ready
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_tdata_o <= '0;
            rx_tvalid_o <= 1'b0;
        end else begin
            rx_tdata_o <= rx_word_i;
            rx_tvalid_o <= rx_word_valid_i && (&lane_ready_q) && (state_d == CH_READY);  // [R4] [R6]
        end
    end

    // Checks of the status behaviour
    sequence s_pin_reset;
        chan_reset_i ##1 1'b1;
    endsequence
    sequence s_link_drop;
        ##2 !link_ready_o;
    endsequence

    a_link_drop_three: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R23]
        s_pin_reset |-> s_link_drop)
        else $error("link ready did not drop three cycles after channel reset");
    a_link_after_lanes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R3]
        $rose(link_ready_o) |-> $past(&lane_ready_q) && $past(state_q) == CH_VERIFY)
        else $error("link ready rose without full initialization");
    a_rx_gate_ready: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R6]
        rx_tvalid_o |-> $past(&lane_ready_q) && link_ready_o)
        else $error("receive data delivered before lanes ready");
    a_tx_hold_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R5]
        tx_en_o && !simplex_q |-> link_ready_o)
        else $error("transmit enabled before link ready");
    a_soft_each_cycle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R7]
        (|(code_invalid_i | disp_err_i)) |=> soft_err_o)
        else $error("symbol error not flagged next cycle");
    a_fatal_restart: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R12]
        (tx_buf_err_i || rx_buf_err_i) |-> ##2 (rx_reset_o && !link_ready_o))
        else $error("fatal error did not restart the channel");
    a_bucket_fatal: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R11]
        bucket_full |=> rx_fatal_o ##1 (state_q == CH_RESET))
        else $error("full bucket did not raise receive fatal");
    a_soft_no_reset: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R13]
        state_q == CH_READY && !restart_req |=> state_q == CH_READY)
        else $error("channel left ready without a fatal cause");
    a_frame_dup_sof: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R14]
        rx_sof_i && in_frame_q |=> frame_err_o)
        else $error("double start of frame not flagged");
    a_tx_ctrl_fatal: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R17]
        tx_bad_ctrl_i |=> tx_fatal_o && !tx_link_ready_o ##1 !tx_en_o)
        else $error("illegal transmit control not fatal");
    a_lane_ready_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // [R2]
        lane_aligned_i[0] && !restart_req && !wd_expired && state_q != CH_RESET |=> lane_ready_o[0])
        else $error("lane ready bit not set after alignment");
endmodule

// File: test/sli_far_end.sv
// Partner model of the far link end: lane training, bonding, verify and sideband relay
module sli_far_end (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    input wire logic core_reset_i,
    input wire logic link_up_i,
    input wire logic rx_aligned_i,
    input wire logic rx_bonded_i,
    input wire logic rx_verify_i,
    input wire logic rx_reset_i,
    output logic [sli_pkg::SLI_LANES-1:0] lane_aligned_o,
    output logic bond_done_o,
    output logic verify_seen_o,
    output logic tx_aligned_o,
    output logic tx_bonded_o,
    output logic tx_verify_o,
    output logic tx_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import sli_pkg::*;
    logic [7:0] tm_q;
    logic [1:0] vc_q;
    logic [7:0] step;
    logic [7:0] step2;
    // Training restarts whenever the core sits in reset, as a real partner would
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i || core_reset_i) begin
            tm_q <= 8'h00;
        end else if (tm_q != 8'hFF) begin
            tm_q <= tm_q + 8'h01;
        end
    end
    // Free divider so verify sequences keep coming after the timer saturates
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vc_q <= 2'h0;
        end else begin
            vc_q <= vc_q + 2'h1;
        end
    end
    // Slow partner takes 40 cycles a step, prompt one 2; both stay under the watchdog
    assign step = slow_i ? 8'h28 : 8'h02;
    assign step2 = {step[6:0], 1'b0};
    assign lane_aligned_o = {SLI_LANES{tm_q >= step}};
    assign bond_done_o = tm_q >= step2;
    assign verify_seen_o = (tm_q > step2) && (vc_q == 2'h0) && !link_up_i;
    // Sideband relayed back one cycle late, the way a back channel would
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {tx_aligned_o, tx_bonded_o, tx_verify_o, tx_reset_o} <= 4'h1;
        end else begin
            {tx_aligned_o, tx_bonded_o, tx_verify_o, tx_reset_o} <=
                {rx_aligned_i, rx_bonded_i, rx_verify_i, rx_reset_i};
        end
    end
endmodule

// File: test/sli_core_test.sv
// Self-checking bench of the serial link init and error block
module sli_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sli_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [SLI_AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_p = 1'b0;
    logic chan_reset = 1'b0;
    logic slow = 1'b0;
    logic [6:0] ev = '0;
    logic [2:0] sed = '0;
    logic [SLI_DW-1:0] word = '0;
    logic wvalid = 1'b0;
    logic [3:0] lmask = 4'h1;
    logic [31:0] rdata;
    logic [3:0] lane_ready;
    logic [3:0] flg;
    logic link_ready, tx_link_ready, tx_en, rx_tvalid;
    logic [SLI_DW-1:0] rx_tdata;
    logic [SLI_LANES-1:0] aligned;
    logic bond, verify, ta, tb, tv, tr, ra, rb, rv, rr;
    logic [31:0] seed = 32'h68DC92F4;
    int errors;
    int checks_done;
    int cnt [4];
    logic [31:0] rdq [$];
    logic [SLI_DW-1:0] wq [$];

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    sli_core #(.WATCHDOG_CYC(64)) sli_core_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .chan_reset_i(chan_reset), .lane_aligned_i(aligned), .bond_done_i(bond),
        .verify_seen_i(verify), .code_invalid_i(ev[0] ? lmask : 4'h0), .disp_err_i(ev[1] ? lmask : 4'h0),
        .rx_buf_err_i(ev[5]), .tx_buf_err_i(ev[4]), .tx_bad_ctrl_i(ev[6]), .rx_unknown_ctrl_i(ev[2]),
        .user_flow_message_len_bad_i(ev[3]), .rx_sof_i(sed[2]), .rx_eof_i(sed[1]), .rx_data_i(sed[0]),
        .rx_word_i(word), .rx_word_valid_i(wvalid), .tx_aligned_i(ta), .tx_bonded_i(tb),
        .tx_verify_i(tv), .tx_reset_i(tr), .lane_ready_o(lane_ready), .link_ready_o(link_ready),
        .tx_link_ready_o(tx_link_ready), .tx_en_o(tx_en), .soft_err_o(flg[0]), .frame_err_o(flg[1]),
        .tx_fatal_o(flg[2]), .rx_fatal_o(flg[3]), .rx_aligned_o(ra), .rx_bonded_o(rb),
        .rx_verify_o(rv), .rx_reset_o(rr), .rx_tdata_o(rx_tdata), .rx_tvalid_o(rx_tvalid));

    sli_far_end sli_far_end_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .core_reset_i(rr), .link_up_i(link_ready), .rx_aligned_i(ra), .rx_bonded_i(rb),
        .rx_verify_i(rv), .rx_reset_i(rr), .lane_aligned_o(aligned), .bond_done_o(bond),
        .verify_seen_o(verify), .tx_aligned_o(ta), .tx_bonded_o(tb), .tx_verify_o(tv), .tx_reset_o(tr));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic rep(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        rep(got, exp);
    endtask
    task automatic chk_word(input logic [SLI_DW-1:0] got, input logic [SLI_DW-1:0] exp);
        rep({16'h0000, got}, {16'h0000, exp});
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        rep({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chk_cnt(input int got, input int exp);
        rep(got, exp);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic endt(input string s);
        $display("test %s done", s);
    endtask
    function automatic logic cond(input int k);
        case (k)
            0: return link_ready === 1'b1;
            1: return link_ready === 1'b0;
            2: return lane_ready === 4'hF;
            default: return tx_link_ready === 1'b1;
        endcase
    endfunction
    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_for(input int k);
        int n;
        n = 0;
        while (!cond(k) && n < 3000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        if (!cond(k)) begin
            errors++;
            $display("wait %0d ran out at %0t", k, $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [SLI_AW-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [SLI_AW-1:0] a, input logic [31:0] e);
        rdq.push_back(e);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
    endtask
    // Raise one error input for n cycles, then count flag pulses of kind f
    task automatic pulse(input int k, input int n, input int f, input int d);
        int c0;
        c0 = cnt[f];
        @(posedge sys_clk_i);
        ev[k] <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        ev[k] <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        chk_cnt(cnt[f] - c0, d);
    endtask
    task automatic send(input int n, input logic live);
        logic [SLI_DW-1:0] w;
        for (int i = 0; i < n; i++) begin
            w = SLI_DW'(rnd());
            @(posedge sys_clk_i);
            word <= w;
            wvalid <= 1'b1;
            if (live) wq.push_back(w);
        end
        @(posedge sys_clk_i);
        wvalid <= 1'b0;
    endtask

    // Result watcher: read data one cycle after the strobe, rx words in arrival order
    always @(posedge sys_clk_i) begin
        if (rd_p) chk_reg(rdata, rdq.pop_front());
        if (rx_tvalid === 1'b1) begin
            if (wq.size() == 0) rep(32'h1, 32'h0);
            else chk_word(rx_tdata, wq.pop_front());
        end
        if (tx_en === 1'b1 && link_ready !== 1'b1) rep(32'h1, 32'h0);
        for (int f = 0; f < 4; f++) if (flg[f] === 1'b1) cnt[f]++;
        rd_p <= reg_rd;
    end

    initial begin
        int c0;
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        chk_flag(link_ready, 1'b0);
        chk_flag(rr, 1'b1);
        rd(SLI_ADDR_LEAK, {24'h000000, SLI_LEAK_THR_RST});
        send(2, 1'b0);
        wait_for(2);
        chk_flag(link_ready, 1'b0);
        wait_for(0);
        chk_flag(tx_en, 1'b1);
        rd(SLI_ADDR_STATUS, 32'h1F);
        rd(4'h2, 32'h0);
        send(6, 1'b1);
        endt("init");
        pulse(0, 2, 0, 2);
        lmask <= 4'h8;
        pulse(1, 1, 0, 1);
        chk_flag(link_ready, 1'b1);
        c0 = cnt[1];
        // Start, start, data, end, end, start, end, idle: double start, double end, empty frame
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            sed <= 3'(24'h90A510 >> (21 - 3 * i));
        end
        repeat (4) @(posedge sys_clk_i);
        chk_cnt(cnt[1] - c0, 3);
        pulse(2, 1, 1, 1);
        pulse(3, 1, 1, 1);
        rd(SLI_ADDR_ERR, 32'h3);
        wr(SLI_ADDR_ERR, 32'h3);
        rd(SLI_ADDR_ERR, 32'h0);
        endt("errors");
        for (int k = 4; k < 7; k++) begin
            pulse(k, 1, (k == 5) ? 3 : 2, 1);
            chk_flag(link_ready, 1'b0);
            wait_for(0);
        end
        endt("fatal");
        slow <= 1'b1;
        @(posedge sys_clk_i);
        chan_reset <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk_flag(link_ready, 1'b0);
        repeat (2) @(posedge sys_clk_i);
        chan_reset <= 1'b0;
        wait_for(0);
        wr(SLI_ADDR_LEAK, 32'h3);
        rd(SLI_ADDR_LEAK, 32'h3);
        c0 = cnt[3];
        // Four errors so a leak tick inside the burst still leaves the bucket at threshold
        pulse(0, 4, 0, 4);
        chk_cnt(cnt[3] > c0, 1);
        wait_for(0);
        wr(SLI_ADDR_CTRL, 32'h2);
        wait_for(1);
        wait_for(0);
        endt("reset");
        wr(SLI_ADDR_CTRL, 32'h1);
        wait_for(3);
        rd(SLI_ADDR_STATUS, 32'h3F);
        rd(SLI_ADDR_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk_i);
        endt("simplex");
        test_done();
    end
endmodule
